// >>> rtl/acc_defs.svh
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

`define ACC_CTRL_ADDR 8'hE8
`define ACC_CTRL_RESET 8'h00
`define ACC_BIT_EN 7
`define ACC_BIT_TM 6
`define ACC_BIT_DONE 5
`define ACC_BIT_BUSY 4
`define ACC_BIT_CM_HI 3
`define ACC_BIT_CM_LO 2
`define ACC_BIT_WIN 1
`define ACC_BIT_LJST 0
`define ACC_TRACK_CLKS 4'h3
`define ACC_CONV_CLKS 4'hB
`define ACC_SAR_DIV_DEFAULT 8'h1F

`endif

// >>> rtl/acc_pkg.sv
`default_nettype none
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_SRC_SOFT = 2'b00,
    ACC_SRC_TMR3 = 2'b01,
    ACC_SRC_STRB = 2'b10,
    ACC_SRC_TMR2 = 2'b11
  } acc_src_t;
  typedef enum logic [1:0] {
    ACC_ST_IDLE = 2'b00,
    ACC_ST_TRACK = 2'b01,
    ACC_ST_CONV = 2'b10
  } acc_state_t;
endpackage : acc_pkg
`default_nettype wire

// >>> rtl/acc_sar_tick_if.sv
`default_nettype none
interface acc_sar_tick_if;
  logic [7:0] div;
  logic run;
  logic tick;
  modport gen (input div, input run, output tick);
  modport use_ (output div, output run, input tick);
endinterface : acc_sar_tick_if
`default_nettype wire

// >>> rtl/acc_sar_tick.sv
`default_nettype none
`include "acc_defs.svh"
module acc_sar_tick
  import acc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  acc_sar_tick_if.gen tk
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic tick_next;

  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!tk.run) begin
      // restart so every conversion sees whole converter clocks
      cnt_next = 8'h00;
    end else if (cnt_reg >= tk.div) begin
      cnt_next = 8'h00;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // unregistered: a converter clock ends div+1 cycles after start, not one cycle later
  assign tk.tick = tick_next;
endmodule : acc_sar_tick
`default_nettype wire

// >>> rtl/acc_ctrl.sv
`default_nettype none
`include "acc_defs.svh"
module acc_ctrl
  import acc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] sar_div,
  input wire logic ext_convert_strobe,
  input wire logic tmr2_overflow,
  input wire logic tmr3_overflow,
  input wire logic window_match,
  output logic conv_powered,
  output logic conv_tracking,
  output logic conv_sample,
  output logic conv_done_pulse
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  acc_state_t state_reg;
  acc_state_t state_next;
  logic [3:0] clk_cnt_reg;
  logic [3:0] clk_cnt_next;
  logic strb_d_reg;
  logic strb_d_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic powered_reg;
  logic powered_next;
  logic track_reg;
  logic track_next;
  logic sample_reg;
  logic sample_next;
  logic done_reg;
  logic done_next;
  logic start;
  logic strb_rise;
  logic wr_hit;
  acc_src_t src;
  logic en;
  logic tm;
  acc_sar_tick_if tk ();

  // single-cycle bus: a write lands on the edge that sees sfr_wr
  assign wr_hit = sfr_wr && (sfr_addr == `ACC_CTRL_ADDR);
  assign en = ctrl_reg[`ACC_BIT_EN];
  assign tm = ctrl_reg[`ACC_BIT_TM];
  assign src = acc_src_t'(ctrl_reg[`ACC_BIT_CM_HI:`ACC_BIT_CM_LO]);
  assign strb_rise = ext_convert_strobe && !strb_d_reg;
  assign tk.div = sar_div;
  assign tk.run = (state_reg != ACC_ST_IDLE);

  // converter clock restarts at every start, so each phase sees whole clocks
  acc_sar_tick u_tick (
    .ref_clk(ref_clk),
    .reset(reset),
    .tk(tk)
  );

  // a start seen outside idle is dropped, not queued
  always_comb begin
    unique case (src)
      ACC_SRC_SOFT: start = wr_hit && sfr_wdata[`ACC_BIT_BUSY];
      ACC_SRC_TMR3: start = tmr3_overflow;
      ACC_SRC_STRB: start = strb_rise;
      ACC_SRC_TMR2: start = tmr2_overflow;
    endcase
  end

  // conversion sequencer
  always_comb begin
    state_next = state_reg;
    clk_cnt_next = clk_cnt_reg;
    done_next = 1'b0;
    if (!en) begin
      state_next = ACC_ST_IDLE;
      clk_cnt_next = 4'h0;
    end else begin
      unique case (state_reg)
        ACC_ST_IDLE: begin
          if (start) begin
            clk_cnt_next = 4'h0;
            // strobe already defined the track window, so go straight to converting
            if (tm && src != ACC_SRC_STRB) begin
              state_next = ACC_ST_TRACK;
            end else begin
              state_next = ACC_ST_CONV;
            end
          end
        end
        ACC_ST_TRACK: begin
          if (tk.tick) begin
            if (clk_cnt_reg == `ACC_TRACK_CLKS - 4'h1) begin
              clk_cnt_next = 4'h0;
              state_next = ACC_ST_CONV;
            end else begin
              clk_cnt_next = clk_cnt_reg + 4'h1;
            end
          end
        end
        ACC_ST_CONV: begin
          if (tk.tick) begin
            if (clk_cnt_reg == `ACC_CONV_CLKS - 4'h1) begin
              clk_cnt_next = 4'h0;
              state_next = ACC_ST_IDLE;
              done_next = 1'b1;
            end else begin
              clk_cnt_next = clk_cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          state_next = ACC_ST_IDLE;
        end
      endcase
    end
  end

  // control register; hardware sets win over same-cycle software clears
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_hit) begin
      ctrl_next = sfr_wdata;
      ctrl_next[`ACC_BIT_BUSY] = ctrl_reg[`ACC_BIT_BUSY]; // write of 1 only starts
    end
    ctrl_next[`ACC_BIT_BUSY] = (state_next != ACC_ST_IDLE);
    if (done_next) begin
      ctrl_next[`ACC_BIT_DONE] = 1'b1;
    end
    if (window_match) begin
      ctrl_next[`ACC_BIT_WIN] = 1'b1;
    end
  end

  // read data holds until the next read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd && sfr_addr == `ACC_CTRL_ADDR) begin
      rdata_next = ctrl_reg;
    end else if (sfr_rd) begin
      rdata_next = 8'h00;
    end
  end

  // power, tracking and sampling all follow the stored enable, so they never disagree
  always_comb begin
    strb_d_next = ext_convert_strobe;
    powered_next = en;
    sample_next = (state_reg == ACC_ST_TRACK || state_reg == ACC_ST_IDLE) &&
      (state_next == ACC_ST_CONV);
    if (!en) begin
      track_next = 1'b0;
    end else if (!tm) begin
      track_next = (state_next != ACC_ST_CONV);
    end else if (src == ACC_SRC_STRB) begin
      track_next = !ext_convert_strobe && state_next == ACC_ST_IDLE;
    end else begin
      track_next = (state_next == ACC_ST_TRACK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // sequencer and control register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= `ACC_CTRL_RESET;
      state_reg <= ACC_ST_IDLE;
      clk_cnt_reg <= 4'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      state_reg <= state_next;
      clk_cnt_reg <= clk_cnt_next;
    end
  end

  // powered lags the enable bit by one cycle, as tracking and sampling do
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strb_d_reg <= 1'b0;
      powered_reg <= 1'b0;
      track_reg <= 1'b0;
      sample_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      strb_d_reg <= strb_d_next;
      powered_reg <= powered_next;
      track_reg <= track_next;
      sample_reg <= sample_next;
      done_reg <= done_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign conv_powered = powered_reg;
  assign conv_tracking = track_reg;
  assign conv_sample = sample_reg;
  assign conv_done_pulse = done_reg;
endmodule : acc_ctrl
`default_nettype wire

// >>> verification/acc_ctrl_asserts.sv
`default_nettype none
module acc_ctrl_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic conv_powered,
  input wire logic conv_tracking,
  input wire logic conv_sample,
  input wire logic conv_done_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // plain reads only, so a same-cycle write cannot blur the flag
  wire logic rd_hit = sfr_rd && !sfr_wr && sfr_addr == 8'hE8;
  pwr_gate_a: assert property ((conv_sample || conv_tracking) |-> conv_powered)
    else $error("active while off");
  samp_once_a: assert property (conv_sample |=> !conv_sample)
    else $error("sample not a pulse");
  done_once_a: assert property (conv_done_pulse |=> !conv_done_pulse)
    else $error("done not a pulse");
  no_trk_conv_a: assert property (conv_sample |-> !conv_tracking)
    else $error("tracking at sample");
  conv_len_a: assert property (conv_sample |=> !conv_done_pulse [*8])
    else $error("conversion too short");
  done_read_a: assert property (conv_done_pulse && !sfr_wr ##1 rd_hit
    |=> sfr_rdata[5:4] == 2'h2) else $error("done flag not set");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  rst_clear_a: assert property (disable iff (1'h0) reset |=> !conv_powered && !conv_sample)
    else $error("outputs live in reset");
endmodule : acc_ctrl_asserts
bind acc_ctrl acc_ctrl_asserts u_chk (.ref_clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_rdata, .conv_powered, .conv_tracking, .conv_sample, .conv_done_pulse);
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, window_match = 0;
  logic ext_convert_strobe = 0, tmr2_overflow = 0, tmr3_overflow = 0;
  logic [7:0] sfr_addr = 8'hE8, sfr_wdata = 8'h00, sar_div = 8'h00, sfr_rdata;
  logic conv_powered, conv_tracking, conv_sample, conv_done_pulse;
  int error_cnt = 0, n_checks = 0, n_smp = 0;
  acc_ctrl u_dut (.ref_clk, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .sar_div, .ext_convert_strobe, .tmr2_overflow, .tmr3_overflow, .window_match,
    .conv_powered, .conv_tracking, .conv_sample, .conv_done_pulse);
  initial forever #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (conv_sample === 1'h1) n_smp++;
  task automatic chk(input logic [7:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] v);
    @(negedge ref_clk) sfr_wdata = v;
    sfr_wr = 1;
    @(negedge ref_clk) sfr_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp, input string nm);
    @(negedge ref_clk) sfr_addr = a;
    sfr_rd = 1;
    @(negedge ref_clk) sfr_rd = 0;
    sfr_addr = 8'hE8;
    chk(sfr_rdata, exp, nm);
  endtask : rd
  // bounded wait: a lost done pulse must not hang the run
  task automatic wait_done(input int lim);
    for (int i = 0; i < lim && conv_done_pulse !== 1'h1; i++) @(negedge ref_clk);
    chk({7'h00, conv_done_pulse}, 8'h01, "done pulse");
  endtask : wait_done
  task automatic fire(input int k);
    @(negedge ref_clk) tmr2_overflow = k == 3;
    tmr3_overflow = k == 1;
    ext_convert_strobe = k == 2;
    @(negedge ref_clk) tmr2_overflow = 0;
    tmr3_overflow = 0;
    ext_convert_strobe = 0;
  endtask : fire
  task automatic t_basic;
    rd(8'hE8, 8'h00, "reset value");
    wr(8'h10);
    repeat (3) @(negedge ref_clk);
    chk(n_smp[7:0], 8'h00, "start while off");
    rd(8'hE8, 8'h00, "busy while off");
    wr(8'h80);
    @(negedge ref_clk);
    chk({conv_powered, conv_tracking}, 8'h03, "enabled idle");
    wr(8'h90);
    rd(8'hE8, 8'h90, "busy set");
    wait_done(40);
    rd(8'hE8, 8'hA0, "done set");
    rd(8'h55, 8'h00, "unmapped");
    rd(8'hE8, 8'hA0, "done sticky");
    wr(8'h80);
    rd(8'hE8, 8'h80, "done cleared");
    @(negedge ref_clk) window_match = 1;
    @(negedge ref_clk) window_match = 0;
    rd(8'hE8, 8'h82, "window flag");
    wr(8'h80);
    rd(8'hE8, 8'h80, "window cleared");
  endtask : t_basic
  task automatic t_track;
    int n;
    n = 0;
    sar_div = 8'h03;
    wr(8'hC0);
    wr(8'hD0);
    for (int i = 0; i < 100 && conv_sample !== 1'h1; i++) begin
      n += conv_tracking;
      @(negedge ref_clk);
    end
    chk(n[7:0], 8'h0C, "track cycles");
    wait_done(100);
    chk({7'h00, conv_tracking}, 8'h00, "low-power idle");
  endtask : t_track
  task automatic t_src;
    logic [7:0] c[4] = '{8'h8C, 8'h84, 8'h88, 8'hC8};
    int s;
    for (int i = 0; i < 4; i++) begin
      wr(c[i]);
      @(negedge ref_clk);
      chk({7'h00, conv_tracking}, 8'h01, "idle tracking");
      s = n_smp;
      for (int k = 1; k < 4; k++) if (k != c[i][3:2]) fire(k);
      chk(n_smp[7:0], s[7:0], "wrong trigger");
      fire(c[i][3:2]);
      wait_done(100);
      rd(8'hE8, c[i] | 8'h20, "source done");
    end
  endtask : t_src
  task automatic test_done;
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 0;
    t_basic;
    t_track;
    t_src;
    test_done;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
